// ---- design/fcf_consts.svh ----
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH

// ==========================================================================
// instruction encoding
`define FCF_MAJOR_FP        6'h32
`define FCF_MINOR_REM_S     8'h06
`define FCF_MINOR_EQ_D      8'h18
`define FCF_MINOR_EQ_S      8'h08
`define FCF_MINOR_GE_D      8'h1B
`define FCF_MINOR_GE_S      8'h0B
`define FCF_MINOR_GT_D      8'h1A
`define FCF_MINOR_GT_S      8'h0A
`define FCF_MINOR_LE_D      8'h1D
`define FCF_MINOR_LE_S      8'h0D
`define FCF_MINOR_LT_D      8'h1C
`define FCF_MINOR_LT_S      8'h0C

// ==========================================================================
// widths
`define FCF_INSTR_W         32
`define FCF_XLEN            64
`define FCF_HALF_W          32
`define FCF_REG_IDX_W       5
`define FCF_SP_EXP_W        8
`define FCF_SP_FRAC_W       23
`define FCF_SP_MANT_W       24
`define FCF_DP_EXP_W        11
`define FCF_DP_FRAC_W       52

// ==========================================================================
// field positions inside a register value
`define FCF_SP_SIGN_BIT     31
`define FCF_SP_EXP_HI       30
`define FCF_SP_EXP_LO       23
`define FCF_SP_FRAC_HI      22
`define FCF_SP_HIDDEN_BIT   23
`define FCF_DP_SIGN_BIT     63
`define FCF_DP_EXP_HI       62
`define FCF_DP_EXP_LO       52
`define FCF_DP_FRAC_HI      51

// ==========================================================================
// values
`define FCF_SP_EXP_ONES     8'hFF
`define FCF_SP_EXP_ZERO     8'h00
`define FCF_SP_EXP_ONE      8'h01
`define FCF_SP_FRAC_ZERO    23'h000000
`define FCF_SP_QNAN         32'h7FC00000
`define FCF_DP_EXP_ONES     11'h7FF
`define FCF_DP_FRAC_ZERO    52'h0000000000000
`define FCF_UPPER_ZERO      32'h00000000
`define FCF_WORD_ZERO       64'h0000000000000000
`define FCF_REG_IDX_ZERO    5'h00
`define FCF_MAG_ZERO        63'h0000000000000000
`define FCF_REM_ZERO        25'h0000000
`define FCF_CNT_ZERO        8'h00
`define FCF_CNT_ONE         8'h01

`endif

// ---- design/fcf_pkg.sv ----
`include "fcf_consts.svh"

package fcf_pkg;

    // ======================================================================
    // instruction word, fields from bit 31 down
    typedef struct packed {
        logic [5:0]                    major;
        logic [`FCF_REG_IDX_W-1:0]     dest;
        logic [`FCF_REG_IDX_W-1:0]     src_a;
        logic [`FCF_REG_IDX_W-1:0]     src_b;
        logic [2:0]                    rsvd;
        logic [7:0]                    minor;
    } fcf_instr_t;

    // ======================================================================
    // general-register write-back
    typedef struct packed {
        logic                          valid;
        logic [`FCF_REG_IDX_W-1:0]     dest;
        logic [`FCF_XLEN-1:0]          data;
    } fcf_wb_t;

    typedef enum logic [2:0] {
        fcf_cmp_none = 3'h0,
        fcf_cmp_eq   = 3'h1,
        fcf_cmp_ge   = 3'h2,
        fcf_cmp_gt   = 3'h3,
        fcf_cmp_le   = 3'h4,
        fcf_cmp_lt   = 3'h5
    } fcf_cmp_kind_t;

    typedef enum logic [1:0] {
        fcf_st_idle = 2'b00,
        fcf_st_div  = 2'b01,
        fcf_st_norm = 2'b11
    } fcf_state_t;

endpackage

// ---- design/fcf_cmp.sv ----
`timescale 1ns/10ps
`include "fcf_consts.svh"

module fcf_cmp
    import fcf_pkg::*;
(
    input  wire logic [`FCF_XLEN-1:0] op_a,
    input  wire logic [`FCF_XLEN-1:0] op_b,
    input  wire logic                 is_double,
    output logic                      unordered,
    output logic                      equal,
    output logic                      less
);

    logic                 sign_a;
    logic                 sign_b;
    logic [`FCF_XLEN-2:0] mag_a;
    logic [`FCF_XLEN-2:0] mag_b;
    logic                 nan_a;
    logic                 nan_b;
    logic                 both_zero;

    // ======================================================================
    // unpack; single values live in the low half
    always_comb begin
        if (is_double) begin
            sign_a = op_a[`FCF_DP_SIGN_BIT];
            sign_b = op_b[`FCF_DP_SIGN_BIT];
            mag_a  = op_a[`FCF_DP_EXP_HI:0];
            mag_b  = op_b[`FCF_DP_EXP_HI:0];
            nan_a  = (op_a[`FCF_DP_EXP_HI:`FCF_DP_EXP_LO] == `FCF_DP_EXP_ONES) &&
                     (op_a[`FCF_DP_FRAC_HI:0] != `FCF_DP_FRAC_ZERO);
            nan_b  = (op_b[`FCF_DP_EXP_HI:`FCF_DP_EXP_LO] == `FCF_DP_EXP_ONES) &&
                     (op_b[`FCF_DP_FRAC_HI:0] != `FCF_DP_FRAC_ZERO);
        end else begin
            sign_a = op_a[`FCF_SP_SIGN_BIT];
            sign_b = op_b[`FCF_SP_SIGN_BIT];
            mag_a  = {`FCF_HALF_W'(0), op_a[`FCF_SP_EXP_HI:0]};
            mag_b  = {`FCF_HALF_W'(0), op_b[`FCF_SP_EXP_HI:0]};
            nan_a  = (op_a[`FCF_SP_EXP_HI:`FCF_SP_EXP_LO] == `FCF_SP_EXP_ONES) &&
                     (op_a[`FCF_SP_FRAC_HI:0] != `FCF_SP_FRAC_ZERO);
            nan_b  = (op_b[`FCF_SP_EXP_HI:`FCF_SP_EXP_LO] == `FCF_SP_EXP_ONES) &&
                     (op_b[`FCF_SP_FRAC_HI:0] != `FCF_SP_FRAC_ZERO);
        end
    end

    // ======================================================================
    // ordering; +0 and -0 compare equal, nan is unordered
    always_comb begin
        both_zero = (mag_a == `FCF_MAG_ZERO) && (mag_b == `FCF_MAG_ZERO);
        unordered = nan_a || nan_b;
        equal     = !unordered && (both_zero || ((sign_a == sign_b) && (mag_a == mag_b)));
        if (unordered || both_zero) begin
            less = 1'b0;
        end else if (sign_a != sign_b) begin
            less = sign_a;
        end else if (sign_a) begin
            less = mag_a > mag_b;
        end else begin
            less = mag_a < mag_b;
        end
    end

endmodule

// ---- design/fcf_unit.sv ----
// Overview of operation
// - single remainder writes low 32 result bits, upper destination half zeroed.
// - equality compare sets the flag when both operands are equal.
// - greater-or-equal compare sets the flag when first is at least second.
// - greater compare sets the flag when first strictly exceeds second.
// - less-or-equal compare sets the flag when first is at most second.
// - less compare sets the flag when first is strictly below second.
// - a compare whose condition fails clears the flag.
// - compares read the A and B operands and write only the flag.
// - major 0x32 minor 0x18 is the double equality compare.
// - major 0x32 minor 0x8 is the single equality compare.
// - major 0x32 minor 0x1b is the double greater-or-equal compare.
// - major 0x32 minor 0xb is single greater-or-equal; fields 6,5,5,5,3,8 bits.
// - major 0x32 minor 0x1a is the double greater compare.
// - major 0x32 minor 0xa is the single greater compare.
// - major 0x32 minor 0xd is the single less-or-equal compare.
// - double less-or-equal and less compares are also provided.
`timescale 1ns/10ps
`include "fcf_consts.svh"

module fcf_unit
    import fcf_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      issue_valid,
    input  wire logic [`FCF_INSTR_W-1:0]   issue_instr,
    input  wire logic [`FCF_XLEN-1:0]      first_source_reg,
    input  wire logic [`FCF_XLEN-1:0]      second_source_reg,
    output logic                           cmp_flag_ff,
    output logic                           flag_valid_ff,
    output logic                           illegal_ff,
    output logic                           busy_ff,
    output fcf_wb_t                        wb_ff
);

    // ======================================================================
    // decode
    fcf_instr_t                  instr;
    fcf_cmp_kind_t               cmp_kind;
    logic                        cmp_double;
    logic                        is_fp_major;
    logic                        is_rem;
    logic                        known_minor;
    logic                        cmp_issue;
    logic                        rem_issue;

    assign instr       = fcf_instr_t'(issue_instr);
    assign is_fp_major = issue_valid && (instr.major == `FCF_MAJOR_FP);

    always_comb begin
        cmp_kind    = fcf_cmp_none;
        cmp_double  = 1'b0;
        is_rem      = 1'b0;
        known_minor = 1'b1;
        case (instr.minor)
            `FCF_MINOR_EQ_D: begin
                cmp_kind   = fcf_cmp_eq;
                cmp_double = 1'b1;
            end
            `FCF_MINOR_EQ_S: begin
                cmp_kind = fcf_cmp_eq;
            end
            `FCF_MINOR_GE_D: begin
                cmp_kind   = fcf_cmp_ge;
                cmp_double = 1'b1;
            end
            `FCF_MINOR_GE_S: begin
                cmp_kind = fcf_cmp_ge;
            end
            `FCF_MINOR_GT_D: begin
                cmp_kind   = fcf_cmp_gt;
                cmp_double = 1'b1;
            end
            `FCF_MINOR_GT_S: begin
                cmp_kind = fcf_cmp_gt;
            end
            `FCF_MINOR_LE_D: begin
                cmp_kind   = fcf_cmp_le;
                cmp_double = 1'b1;
            end
            `FCF_MINOR_LE_S: begin
                cmp_kind = fcf_cmp_le;
            end
            `FCF_MINOR_LT_D: begin
                cmp_kind   = fcf_cmp_lt;
                cmp_double = 1'b1;
            end
            `FCF_MINOR_LT_S: begin
                cmp_kind = fcf_cmp_lt;
            end
            `FCF_MINOR_REM_S: begin
                is_rem = 1'b1;
            end
            default: begin
                known_minor = 1'b0;
            end
        endcase
    end

    // compares run even while a remainder is in flight; they share nothing with it
    assign cmp_issue = is_fp_major && (cmp_kind != fcf_cmp_none);
    assign rem_issue = is_fp_major && is_rem && !busy_ff;

    // ======================================================================
    // compare and flag
    logic cmp_unordered;
    logic cmp_equal;
    logic cmp_less;
    logic cmp_result;

    fcf_cmp u_cmp (
        .op_a      (first_source_reg),
        .op_b      (second_source_reg),
        .is_double (cmp_double),
        .unordered (cmp_unordered),
        .equal     (cmp_equal),
        .less      (cmp_less)
    );

    // nan operands make every ordered relation false
    always_comb begin
        case (cmp_kind)
            fcf_cmp_eq: cmp_result = cmp_equal;
            fcf_cmp_ge: cmp_result = !cmp_unordered && !cmp_less;
            fcf_cmp_gt: cmp_result = !cmp_unordered && !cmp_less && !cmp_equal;
            fcf_cmp_le: cmp_result = cmp_less || cmp_equal;
            fcf_cmp_lt: cmp_result = cmp_less;
            default:    cmp_result = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmp_flag_ff <= 1'b0;
        end else if (cmp_issue) begin
            cmp_flag_ff <= cmp_result;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_valid_ff <= 1'b0;
        end else begin
            flag_valid_ff <= cmp_issue;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= is_fp_major && !known_minor;
        end
    end

    // ======================================================================
    // remainder operand unpack
    logic                        a_sign;
    logic [`FCF_SP_EXP_W-1:0]    a_exp;
    logic [`FCF_SP_EXP_W-1:0]    b_exp;
    logic [`FCF_SP_EXP_W-1:0]    a_exp_eff;
    logic [`FCF_SP_EXP_W-1:0]    b_exp_eff;
    logic [`FCF_SP_MANT_W-1:0]   a_mant;
    logic [`FCF_SP_MANT_W-1:0]   b_mant;
    logic                        a_frac_zero;
    logic                        b_frac_zero;
    logic                        rem_nan;
    logic                        rem_pass_a;

    always_comb begin
        a_sign      = first_source_reg[`FCF_SP_SIGN_BIT];
        a_exp       = first_source_reg[`FCF_SP_EXP_HI:`FCF_SP_EXP_LO];
        b_exp       = second_source_reg[`FCF_SP_EXP_HI:`FCF_SP_EXP_LO];
        a_frac_zero = first_source_reg[`FCF_SP_FRAC_HI:0] == `FCF_SP_FRAC_ZERO;
        b_frac_zero = second_source_reg[`FCF_SP_FRAC_HI:0] == `FCF_SP_FRAC_ZERO;
        // subnormals sit at the minimum exponent without the hidden one
        a_exp_eff   = (a_exp == `FCF_SP_EXP_ZERO) ? `FCF_SP_EXP_ONE : a_exp;
        b_exp_eff   = (b_exp == `FCF_SP_EXP_ZERO) ? `FCF_SP_EXP_ONE : b_exp;
        a_mant      = {a_exp != `FCF_SP_EXP_ZERO, first_source_reg[`FCF_SP_FRAC_HI:0]};
        b_mant      = {b_exp != `FCF_SP_EXP_ZERO, second_source_reg[`FCF_SP_FRAC_HI:0]};
        // nan in, infinite dividend or zero divisor give the quiet nan
        rem_nan     = (a_exp == `FCF_SP_EXP_ONES) ||
                      ((b_exp == `FCF_SP_EXP_ONES) && !b_frac_zero) ||
                      ((b_exp == `FCF_SP_EXP_ZERO) && b_frac_zero);
        // infinite divisor, zero dividend or |a| < |b| return a unchanged
        rem_pass_a  = (b_exp == `FCF_SP_EXP_ONES) ||
                      ((a_exp == `FCF_SP_EXP_ZERO) && a_frac_zero) ||
                      (a_exp_eff < b_exp_eff) ||
                      ((a_exp_eff == b_exp_eff) && (a_mant < b_mant));
    end

    // ======================================================================
    // remainder sequencer: one quotient bit per cycle, then normalise
    fcf_state_t                  state_ff;
    fcf_state_t                  nxt_state;
    logic [`FCF_SP_MANT_W:0]     rem_ff;
    logic [`FCF_SP_MANT_W:0]     nxt_rem;
    logic [`FCF_SP_MANT_W-1:0]   div_ff;
    logic [`FCF_SP_EXP_W-1:0]    cnt_ff;
    logic [`FCF_SP_EXP_W-1:0]    exp_ff;
    logic                        sign_ff;
    logic [`FCF_REG_IDX_W-1:0]   dest_ff;
    logic [`FCF_SP_MANT_W:0]     rem_sub;
    logic                        norm_done;
    logic                        finish;
    logic [`FCF_HALF_W-1:0]      finish_word;

    assign rem_sub   = (rem_ff >= {1'b0, div_ff}) ? (rem_ff - {1'b0, div_ff}) : rem_ff;
    assign norm_done = (rem_ff == `FCF_REM_ZERO) || rem_ff[`FCF_SP_HIDDEN_BIT] ||
                       (exp_ff == `FCF_SP_EXP_ONE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fcf_st_idle: begin
                if (rem_issue && !rem_nan && !rem_pass_a) begin
                    nxt_state = fcf_st_div;
                end
            end
            fcf_st_div: begin
                if (cnt_ff == `FCF_CNT_ZERO) begin
                    nxt_state = fcf_st_norm;
                end
            end
            fcf_st_norm: begin
                if (norm_done) begin
                    nxt_state = fcf_st_idle;
                end
            end
            default: begin
                nxt_state = fcf_st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= fcf_st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_state != fcf_st_idle;
        end
    end

    // partial remainder stays below twice a normal divisor, so one spare bit suffices
    always_comb begin
        nxt_rem = rem_ff;
        case (state_ff)
            fcf_st_idle: nxt_rem = {1'b0, a_mant};
            fcf_st_div:  nxt_rem = (cnt_ff == `FCF_CNT_ZERO) ? rem_sub : {rem_sub[`FCF_SP_MANT_W-1:0], 1'b0};
            fcf_st_norm: nxt_rem = norm_done ? rem_ff : {rem_ff[`FCF_SP_MANT_W-1:0], 1'b0};
            default:     nxt_rem = rem_ff;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rem_ff <= `FCF_REM_ZERO;
        end else begin
            rem_ff <= nxt_rem;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_ff <= `FCF_CNT_ZERO;
        end else if (state_ff == fcf_st_idle) begin
            cnt_ff <= a_exp_eff - b_exp_eff;
        end else if ((state_ff == fcf_st_div) && (cnt_ff != `FCF_CNT_ZERO)) begin
            cnt_ff <= cnt_ff - `FCF_CNT_ONE;
        end
    end

    // result exponent starts at the divisor's and only falls while normalising
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            exp_ff <= `FCF_SP_EXP_ONE;
        end else if (state_ff == fcf_st_idle) begin
            exp_ff <= b_exp_eff;
        end else if ((state_ff == fcf_st_norm) && !norm_done) begin
            exp_ff <= exp_ff - `FCF_SP_EXP_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_ff  <= {`FCF_SP_MANT_W{1'b0}};
            sign_ff <= 1'b0;
            dest_ff <= `FCF_REG_IDX_ZERO;
        end else if (state_ff == fcf_st_idle) begin
            div_ff  <= b_mant;
            sign_ff <= a_sign;
            dest_ff <= instr.dest;
        end
    end

    // ======================================================================
    // result packing and write-back
    always_comb begin
        finish      = 1'b0;
        finish_word = `FCF_SP_QNAN;
        if ((state_ff == fcf_st_idle) && rem_issue && rem_nan) begin
            finish = 1'b1;
        end else if ((state_ff == fcf_st_idle) && rem_issue && rem_pass_a) begin
            finish      = 1'b1;
            finish_word = first_source_reg[`FCF_HALF_W-1:0];
        end else if ((state_ff == fcf_st_norm) && norm_done) begin
            finish      = 1'b1;
            // remainder is exact, so truncation loses nothing
            finish_word = {sign_ff,
                           rem_ff[`FCF_SP_HIDDEN_BIT] ? exp_ff : `FCF_SP_EXP_ZERO,
                           rem_ff[`FCF_SP_FRAC_HI:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wb_ff <= '{valid: 1'b0, dest: `FCF_REG_IDX_ZERO, data: `FCF_WORD_ZERO};
        end else begin
            wb_ff.valid <= finish;
            if (finish) begin
                wb_ff.dest <= (state_ff == fcf_st_idle) ? instr.dest : dest_ff;
                wb_ff.data <= {`FCF_UPPER_ZERO, finish_word};
            end
        end
    end

endmodule

// ---- verification/fcf_unit_chk.sv ----
`timescale 1ns/10ps
`include "fcf_consts.svh"

module fcf_unit_chk
    import fcf_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [63:0] first_source_reg,
    input wire logic [63:0] second_source_reg,
    input wire logic        cmp_flag_ff,
    input wire logic        flag_valid_ff,
    input wire logic        illegal_ff,
    input wire logic        busy_ff,
    input wire fcf_wb_t     wb_ff
);
    // ==========================================================================
    // decode of the offered word
    logic       is_fp;
    logic       is_cmp;
    logic       is_rem;
    logic [7:0] mnr;
    logic       same_lo;
    assign mnr     = issue_instr[7:0];
    assign is_fp   = issue_valid && (issue_instr[31:26] == `FCF_MAJOR_FP);
    assign is_cmp  = is_fp && (mnr inside {8'h18, 8'h08, 8'h1B, 8'h0B, 8'h1A,
                                           8'h0A, 8'h1D, 8'h0D, 8'h1C, 8'h0C});
    assign is_rem  = is_fp && (mnr == `FCF_MINOR_REM_S) && !busy_ff;
    assign same_lo = first_source_reg[31:0] == second_source_reg[31:0];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================================
    // assertions
    cmp_answer_a: assert property (is_cmp |=> flag_valid_ff)
        else $error("compare not answered next cycle");
    flag_cause_a: assert property (flag_valid_ff |-> $past(is_cmp))
        else $error("flag update without a compare");
    flag_hold_a: assert property (!$past(is_cmp) |-> $stable(cmp_flag_ff))
        else $error("flag moved without a compare");
    eq_single_a: assert property (is_cmp && mnr == `FCF_MINOR_EQ_S && same_lo
        && first_source_reg[30:23] != 8'hFF |=> cmp_flag_ff)
        else $error("equal singles left flag clear");
    lt_single_a: assert property (is_cmp && mnr == `FCF_MINOR_LT_S && same_lo
        |=> !cmp_flag_ff)
        else $error("less-than of equal singles set flag");
    bad_minor_a: assert property (is_fp && (mnr == 8'h09 || mnr == 8'h19)
        |=> illegal_ff && !flag_valid_ff)
        else $error("unknown minor not refused");
    no_cmp_wb_a: assert property (is_cmp && !busy_ff |=> !wb_ff.valid)
        else $error("compare wrote a register");
    rem_start_a: assert property (is_rem |=> busy_ff || wb_ff.valid)
        else $error("remainder not started");
    rem_bound_a: assert property (is_rem |-> ##[1:300] wb_ff.valid)
        else $error("remainder never wrote back");
    wb_upper_a: assert property (wb_ff.valid |-> wb_ff.data[63:32] == `FCF_UPPER_ZERO)
        else $error("upper half of result not zero");
    busy_end_a: assert property ($fell(busy_ff) |-> wb_ff.valid)
        else $error("busy ended without write-back");
endmodule

// ---- verification/fcf_pipe_model.sv ----
`timescale 1ns/10ps

module fcf_pipe_model (
    input  wire logic   core_clk,
    output logic        issue_valid,
    output logic [31:0] issue_instr,
    output logic [63:0] first_source_reg,
    output logic [63:0] second_source_reg
);
    initial begin
        issue_valid       = 1'b0;
        issue_instr       = 32'h00000000;
        first_source_reg  = 64'h0;
        second_source_reg = 64'h0;
    end

    task automatic send(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        @(negedge core_clk);
        issue_valid       = 1'b1;
        issue_instr       = ins;
        first_source_reg  = a;
        second_source_reg = b;
    endtask

    // stale operands are not held: inverted so nothing can lean on them
    task automatic idle();
        @(negedge core_clk);
        issue_valid       = 1'b0;
        issue_instr       = ~issue_instr;
        first_source_reg  = ~first_source_reg;
        second_source_reg = ~second_source_reg;
    endtask
endmodule

// ---- verification/fcf_unit_test.sv ----
`timescale 1ns/10ps
`include "fcf_consts.svh"

module fcf_unit_test
    import fcf_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic        issue_valid;
    logic [31:0] issue_instr;
    logic [63:0] first_source_reg;
    logic [63:0] second_source_reg;
    logic        cmp_flag_ff;
    logic        flag_valid_ff;
    logic        illegal_ff;
    logic        busy_ff;
    fcf_wb_t     wb_ff;
    int          error_cnt;
    int          num_checks;

    // single operands carry unequal upper halves on purpose
    localparam logic [63:0] S1  = 64'h5A5A5A5A3F800000;
    localparam logic [63:0] S1B = 64'h123456783F800000;
    localparam logic [63:0] S2  = 64'hA5A5A5A540000000;
    localparam logic [63:0] SM1 = 64'h00000000BF800000;
    localparam logic [63:0] D1  = 64'h3FF0000000000000;
    localparam logic [63:0] D2  = 64'h4000000000000000;

    fcf_pipe_model pipe (.core_clk(core_clk), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .first_source_reg(first_source_reg),
        .second_source_reg(second_source_reg));

    fcf_unit dut (.core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .first_source_reg(first_source_reg),
        .second_source_reg(second_source_reg), .cmp_flag_ff(cmp_flag_ff),
        .flag_valid_ff(flag_valid_ff), .illegal_ff(illegal_ff), .busy_ff(busy_ff),
        .wb_ff(wb_ff));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] mk(input logic [5:0] maj, input logic [7:0] mnr);
        return {maj, 5'h03, 5'h01, 5'h02, 3'h5, mnr};
    endfunction

    task automatic cmp_case(input logic [7:0] mnr, input logic [63:0] a,
                            input logic [63:0] b, input logic exp);
        pipe.send(mk(`FCF_MAJOR_FP, mnr), a, b);
        pipe.idle();
        chk("flag_valid", 64'h1, 64'(flag_valid_ff));
        chk("cmp_flag", 64'(exp), 64'(cmp_flag_ff));
        chk("wb_valid", 64'h0, 64'(wb_ff.valid));
    endtask

    task automatic t_reset();
        chk("flag after reset", 64'h0, 64'(cmp_flag_ff));
        chk("busy after reset", 64'h0, 64'(busy_ff));
        chk("wb after reset", 64'h0, 64'(wb_ff.data));
    endtask

    task automatic t_compares();
        cmp_case(8'h08, S1, S1B, 1'b1);
        cmp_case(8'h08, S1, S2, 1'b0);
        cmp_case(8'h08, 64'h0, 64'h80000000, 1'b1);
        cmp_case(8'h18, D1, D2, 1'b0);
        cmp_case(8'h18, D2, D2, 1'b1);
        cmp_case(8'h0B, S1, S2, 1'b0);
        cmp_case(8'h0B, S1, S1B, 1'b1);
        cmp_case(8'h1B, D1, D2, 1'b0);
        cmp_case(8'h1B, D2, D1, 1'b1);
        cmp_case(8'h0A, S1, S1B, 1'b0);
        cmp_case(8'h0A, S2, S1, 1'b1);
        cmp_case(8'h0A, SM1, S1, 1'b0);
        cmp_case(8'h1A, D2, D1, 1'b1);
        cmp_case(8'h1A, D1, D1, 1'b0);
        cmp_case(8'h0D, S1, S1B, 1'b1);
        cmp_case(8'h0D, S2, S1, 1'b0);
        cmp_case(8'h1D, D1, D2, 1'b1);
        cmp_case(8'h1D, D2, D1, 1'b0);
        cmp_case(8'h0C, SM1, S1, 1'b1);
        cmp_case(8'h0C, 64'h7FC00000, S1, 1'b0);
        cmp_case(8'h1C, D1, D2, 1'b1);
        cmp_case(8'h1C, D2, D2, 1'b0);
    endtask

    task automatic t_back_to_back();
        pipe.send(mk(`FCF_MAJOR_FP, 8'h08), S1, S1B);
        pipe.send(mk(`FCF_MAJOR_FP, 8'h0C), S1, S1B);
        chk("first flag", 64'h1, 64'(cmp_flag_ff));
        pipe.idle();
        chk("second valid", 64'h1, 64'(flag_valid_ff));
        chk("second flag", 64'h0, 64'(cmp_flag_ff));
    endtask

    task automatic t_illegal();
        pipe.send(mk(`FCF_MAJOR_FP, 8'h09), S1, S1);
        pipe.idle();
        chk("illegal", 64'h1, 64'(illegal_ff));
        chk("flag kept", 64'h0, 64'(cmp_flag_ff));
        pipe.send(mk(6'h00, 8'h08), S1, S1);
        pipe.idle();
        chk("foreign illegal", 64'h0, 64'(illegal_ff));
        chk("foreign valid", 64'h0, 64'(flag_valid_ff));
    endtask

    task automatic t_remainder();
        int i;
        pipe.send(mk(`FCF_MAJOR_FP, `FCF_MINOR_REM_S), 64'hFFFFFFFF40E00000, S2);
        pipe.send(mk(`FCF_MAJOR_FP, 8'h0A), S2, S1);
        pipe.idle();
        @(negedge core_clk);
        chk("flag while busy", 64'h1, 64'(cmp_flag_ff));
        chk("busy", 64'h1, 64'(busy_ff));
        for (i = 0; i < 300 && wb_ff.valid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk("rem valid", 64'h1, 64'(wb_ff.valid));
        chk("rem data", 64'h000000003F800000, wb_ff.data);
        chk("rem dest", 64'h3, 64'(wb_ff.dest));
        // zero divisor finishes at once with the quiet nan
        pipe.send(mk(`FCF_MAJOR_FP, `FCF_MINOR_REM_S), SM1, 64'h0);
        pipe.idle();
        chk("rem nan", 64'h000000007FC00000, wb_ff.data);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        error_cnt  = 0;
        num_checks = 0;
        rst_n      = 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_compares();
        t_back_to_back();
        t_illegal();
        t_remainder();
        print_verdict();
    end
endmodule

bind fcf_unit fcf_unit_chk chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue_instr(issue_instr),
    .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
    .cmp_flag_ff(cmp_flag_ff), .flag_valid_ff(flag_valid_ff), .illegal_ff(illegal_ff),
    .busy_ff(busy_ff), .wb_ff(wb_ff));
